// File: hdl/psp_pkg.sv
// package: constants and carrier types for the parallel slave port
package psp_pkg;
   localparam int          PSP_DATA_W      = 8;
   localparam int          PSP_FIFO_DEPTH  = 16;
   localparam int          PSP_SYNC_STAGES = 3;
   // clock phases of one instruction cycle, counted on core_clk
   localparam logic [1:0]  PSP_PHASE_TWO   = 2'h1;
   localparam logic [1:0]  PSP_PHASE_FOUR  = 2'h3;
   localparam logic [7:0]  PSP_LATCH_RST   = 8'h00;
   localparam logic [1:0]  PSP_PHASE_RST   = 2'h0;

   // external strobes, active low, already synchronised
   typedef struct packed {
      logic rd_n;
      logic wr_n;
      logic cs_n;
   } psp_strobes_t;

   // firmware-visible status
   typedef struct packed {
      logic input_buffer_full;
      logic output_buffer_full;
      logic input_overrun;
      logic slave_port_irq_flag;
   } psp_status_t;

   typedef enum logic [1:0] {
      PSP_IDLE  = 2'b00,
      PSP_WRITE = 2'b01,
      PSP_READ  = 2'b10,
      PSP_WAIT  = 2'b11
   } psp_state_t;
endpackage

// File: hdl/psp_sync.sv
// three-stage synchroniser with agreement filter for strobe pins
`timescale 1ns/1ps
module psp_sync #(
   parameter int WIDTH = 3
) (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             srst,
   // pins in, filtered level out
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] level_out
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         stage1 <= '1;
         stage2 <= '1;
         stage3 <= '1;
      end else begin
         stage1 <= pin_in;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // change counts once stages two and three agree
   always_ff @(posedge core_clk) begin
      if (srst) begin
         level_out <= '1;
      end else begin
         for (int i = 0; i < WIDTH; i++) begin
            if (stage2[i] == stage3[i]) begin
               level_out[i] <= stage3[i];
            end
         end
      end
   end
endmodule

// File: hdl/psp_fifo.sv
// synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module psp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             srst,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_ptr];

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule

// File: hdl/psp_core.sv
// parallel slave port: strobe handling, latches, flags, FIFO path
// Contract
// (R1) enable makes port D an 8-bit slave port
// (R2) enable turns three E pins into strobes
// (R3) firmware sets E direction bits to input
// (R4) firmware sets analog config to digital I/O
// (R5) output and input latches at one address
// (R6) direction register ignored in slave mode
// (R7) write release sets input full at phase four
// (R8) write completion sets irq flag same cycle
// (R9) only firmware read clears input full; code also clears it on reset and while mode is off
// (R10) second unread write sets overrun flag
// (R11) read start clears output full immediately
// (R12) read release sets irq flag at phase four
// (R13) output full stays low until firmware write
// (R14) mode off holds both full flags clear
// (R15) firmware clears overrun after leaving mode
// (R16) irq flag sticky, firmware clears, enable masks
// (R17) host uses plain latch, no handshake
// (R18) drive data only during chip select and read
// (R19) strobes synchronised before release detection
`timescale 1ns/1ps
module psp_core
   import psp_pkg::*;
#(
   parameter int DATA_W     = psp_pkg::PSP_DATA_W,
   parameter int FIFO_DEPTH = psp_pkg::PSP_FIFO_DEPTH
) (
   // clock and reset
   input  wire logic                core_clk,
   input  wire logic                srst,
   // configuration
   input  wire logic                slave_port_enable,
   input  wire logic                slave_port_irq_enable,
   input  wire logic [DATA_W-1:0]   port_d_direction,
   input  wire logic [DATA_W-1:0]   port_d_gpio_out,
   // strobe pins, active low
   input  wire logic                read_strobe_pin_n,
   input  wire logic                write_strobe_pin_n,
   input  wire logic                chip_select_pin_n,
   // data pins as three signals
   input  wire logic [DATA_W-1:0]   port_d_in,
   output logic      [DATA_W-1:0]   port_d_out,
   output logic      [DATA_W-1:0]   port_d_oe,
   // firmware port_d_latch access
   input  wire logic                fw_write,
   input  wire logic [DATA_W-1:0]   fw_wdata,
   output logic                     fw_write_ready,
   input  wire logic                fw_read,
   output logic      [DATA_W-1:0]   fw_rdata,
   input  wire logic                fw_clear_irq,
   input  wire logic                fw_clear_overrun,
   // status and interrupt
   output psp_pkg::psp_status_t     status,
   output logic                     slave_port_irq
);
   import psp_pkg::*;

   psp_strobes_t          strb;
   logic [2:0]            strb_raw;
   logic [1:0]            phase;
   psp_state_t            state;
   psp_state_t            next_state;
   logic                  pend_write;
   logic                  pend_read;
   logic                  wr_active;
   logic                  rd_active;
   logic                  write_done;
   logic                  read_done;
   logic [DATA_W-1:0]     input_latch;
   logic [DATA_W-1:0]     output_latch;
   logic [DATA_W-1:0]     fifo_data;
   logic                  fifo_valid;
   logic                  fifo_pop;
   logic                  input_buffer_full;
   logic                  output_buffer_full;
   logic                  input_overrun;
   logic                  slave_port_irq_flag;
   logic                  fire;

   // synchronised strobes in {rd,wr,cs} order
   psp_sync #(
      .WIDTH (3)
   ) u_sync (
      .core_clk  (core_clk),
      .srst      (srst),
      .pin_in    ({read_strobe_pin_n, write_strobe_pin_n, chip_select_pin_n}), // [R2]
      .level_out (strb_raw)                                                  // [R19]
   );
   assign strb = psp_strobes_t'(strb_raw);

   assign wr_active = slave_port_enable && !strb.cs_n && !strb.wr_n; // [R1]
   assign rd_active = slave_port_enable && !strb.cs_n && !strb.rd_n;

   // four-phase instruction cycle
   always_ff @(posedge core_clk) begin
      if (srst) begin
         phase <= PSP_PHASE_RST;
      end else begin
         phase <= phase + 2'h1;
      end
   end

   // access tracking state machine
   always_comb begin
      next_state = state;
      case (state)
         PSP_IDLE: begin
            if (wr_active) begin
               next_state = PSP_WRITE;
            end else if (rd_active) begin
               next_state = PSP_READ;
            end
         end
         PSP_WRITE: begin
            if (!wr_active) begin
               next_state = PSP_WAIT;
            end
         end
         PSP_READ: begin
            if (!rd_active) begin
               next_state = PSP_WAIT;
            end
         end
         PSP_WAIT: begin
            if (fire) begin
               next_state = PSP_IDLE;
            end
         end
         default: begin
            next_state = PSP_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         state <= PSP_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // release arms a two-step wait: next phase two, then phase four
   always_ff @(posedge core_clk) begin
      if (srst) begin
         pend_write <= 1'b0;
         pend_read  <= 1'b0;
      end else if (state == PSP_WRITE && !wr_active) begin
         pend_write <= 1'b1;
      end else if (state == PSP_READ && !rd_active) begin
         pend_read <= 1'b1;
      end else if (fire) begin
         pend_write <= 1'b0;
         pend_read  <= 1'b0;
      end
   end

   logic seen_two;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         seen_two <= 1'b0;
      end else if (state != PSP_WAIT) begin
         seen_two <= 1'b0;
      end else if (phase == PSP_PHASE_TWO) begin
         seen_two <= 1'b1;
      end
   end

   assign fire       = (state == PSP_WAIT) && seen_two && (phase == PSP_PHASE_FOUR);
   assign write_done = fire && pend_write; // [R7]
   assign read_done  = fire && pend_read;  // [R12]

   // host write data captured while strobes are low
   always_ff @(posedge core_clk) begin
      if (srst) begin
         input_latch <= PSP_LATCH_RST;
      end else if (wr_active) begin
         input_latch <= port_d_in;
      end
   end

   // written bytes queue for firmware
   psp_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .core_clk  (core_clk),
      .srst      (srst),
      .in_valid  (write_done),
      .in_ready  (),
      .in_data   (input_latch),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_data)
   );
   assign fifo_pop = fw_read && fifo_valid;

   // firmware read returns the input side of the latch pair
   always_ff @(posedge core_clk) begin
      if (srst) begin
         fw_rdata <= PSP_LATCH_RST;
      end else if (fw_read) begin
         fw_rdata <= fifo_valid ? fifo_data : input_latch; // [R5]
      end
   end

   // firmware write loads output latch; refused while host reads it
   assign fw_write_ready = !rd_active;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         output_latch <= PSP_LATCH_RST;
      end else if (fw_write && fw_write_ready) begin
         output_latch <= fw_wdata; // [R5]
      end
   end

   // input full: set on write completion, cleared by firmware read
   always_ff @(posedge core_clk) begin
      if (srst || !slave_port_enable) begin
         input_buffer_full <= 1'b0; // [R14]
      end else if (write_done) begin
         input_buffer_full <= 1'b1; // [R7]
      end else if (fw_read) begin
         input_buffer_full <= 1'b0; // [R9]
      end
   end

   // overrun: survives mode exit, firmware clears
   always_ff @(posedge core_clk) begin
      if (srst) begin
         input_overrun <= 1'b0;
      end else if (write_done && input_buffer_full && !fw_read) begin
         input_overrun <= 1'b1; // [R10]
      end else if (fw_clear_overrun) begin
         input_overrun <= 1'b0; // [R15]
      end
   end

   // output full: firmware write sets, read start clears
   always_ff @(posedge core_clk) begin
      if (srst || !slave_port_enable) begin
         output_buffer_full <= 1'b0; // [R14]
      end else if (state == PSP_IDLE && rd_active) begin
         output_buffer_full <= 1'b0; // [R11]
      end else if (fw_write && fw_write_ready) begin
         output_buffer_full <= 1'b1; // [R13]
      end
   end

   // sticky interrupt flag, set wins over clear
   always_ff @(posedge core_clk) begin
      if (srst) begin
         slave_port_irq_flag <= 1'b0;
      end else if (write_done || read_done) begin
         slave_port_irq_flag <= 1'b1; // [R8] [R16]
      end else if (fw_clear_irq) begin
         slave_port_irq_flag <= 1'b0; // [R16]
      end
   end

   assign slave_port_irq = slave_port_irq_flag && slave_port_irq_enable; // [R16]

   assign status = '{input_buffer_full:   input_buffer_full,
                     output_buffer_full:  output_buffer_full,
                     input_overrun:       input_overrun,
                     slave_port_irq_flag: slave_port_irq_flag};

   // pin drive: host strobes own direction in slave mode
   always_comb begin
      if (slave_port_enable) begin
         port_d_out = output_latch;
         port_d_oe  = rd_active ? '1 : '0;                // [R6] [R18] [R17]
      end else begin
         port_d_out = port_d_gpio_out;
         port_d_oe  = ~port_d_direction;
      end
   end

   // assertions
   wr_irq_same_a: assert property (@(posedge core_clk) disable iff (srst) // [R8]
      $rose(input_buffer_full) |-> $rose(slave_port_irq_flag) || $past(slave_port_irq_flag))
      else $error("input full rose without irq flag");
   ibf_phase_a: assert property (@(posedge core_clk) disable iff (srst) // [R7]
      $rose(input_buffer_full) |-> $past(phase) == PSP_PHASE_FOUR)
      else $error("input full set off phase four");
   ibf_hold_a: assert property (@(posedge core_clk) disable iff (srst) // [R9]
      input_buffer_full && slave_port_enable && !fw_read ##1 slave_port_enable
      |-> input_buffer_full)
      else $error("input full cleared without read");
   ovr_set_a: assert property (@(posedge core_clk) disable iff (srst) // [R10]
      write_done && input_buffer_full && !fw_read |=> input_overrun)
      else $error("overrun not flagged");
   obf_clear_a: assert property (@(posedge core_clk) disable iff (srst) // [R11]
      slave_port_enable && state == PSP_IDLE && rd_active |=> !output_buffer_full)
      else $error("output full not cleared on read");
   obf_stay_a: assert property (@(posedge core_clk) disable iff (srst) // [R13]
      !output_buffer_full && !(fw_write && fw_write_ready) |=> !output_buffer_full)
      else $error("output full rose without write");
   mode_off_a: assert property (@(posedge core_clk) disable iff (srst) // [R14]
      !slave_port_enable |=> !input_buffer_full && !output_buffer_full)
      else $error("flags not held clear");
   irq_mask_a: assert property (@(posedge core_clk) disable iff (srst) // [R16]
      slave_port_irq |-> slave_port_irq_enable && slave_port_irq_flag)
      else $error("irq not masked");
   rd_irq_a: assert property (@(posedge core_clk) disable iff (srst) // [R12]
      state == PSP_READ && !rd_active |-> ##[2:8] slave_port_irq_flag)
      else $error("read completion irq missing");
   drive_a: assert property (@(posedge core_clk) disable iff (srst) // [R18]
      slave_port_enable && port_d_oe != '0 |-> !strb.cs_n && !strb.rd_n)
      else $error("data driven outside read");
endmodule

// File: test/psp_host_model.sv
// external microprocessor model: strobes and data for the slave port
`timescale 1ns/1ps
module psp_host_model (
   // clock
   input  wire logic                          core_clk,
   // resolved data wires
   input  wire logic [psp_pkg::PSP_DATA_W-1:0] bus_level,
   // strobes, active low
   output logic                               cs_n,
   output logic                               wr_n,
   output logic                               rd_n,
   // host share of the data wires
   output logic      [psp_pkg::PSP_DATA_W-1:0] host_drive
);
   import psp_pkg::*;
   logic                  drv_en;
   logic [PSP_DATA_W-1:0] drv_data;
   initial begin
      cs_n     = 1'b1; // strobe pins used as digital inputs only
      wr_n     = 1'b1;
      rd_n     = 1'b1;
      drv_en   = 1'b0;
      drv_data = 8'h00;
   end
   // released wires show the inverse of the last byte
   assign host_drive = drv_en ? drv_data : ~drv_data;
   // plain latch write, data held 6 cycles past the strobe
   task automatic write_byte(input logic [7:0] value, input int hold);
      @(posedge core_clk);
      cs_n     <= 1'b0;
      wr_n     <= 1'b0;
      drv_en   <= 1'b1;
      drv_data <= value;
      repeat (hold) @(posedge core_clk);
      cs_n <= 1'b1;
      wr_n <= 1'b1;
      repeat (6) @(posedge core_clk);
      drv_en <= 1'b0;
      repeat (10) @(posedge core_clk);
   endtask
   // plain latch read, sampled at the releasing edge
   task automatic read_byte(output logic [7:0] value, input int hold);
      @(posedge core_clk);
      cs_n <= 1'b0;
      rd_n <= 1'b0;
      repeat (hold) @(posedge core_clk);
      value = bus_level;
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      repeat (16) @(posedge core_clk);
   endtask
endmodule

// File: test/psp_core_tb.sv
// self-checking bench for the parallel slave port core
`timescale 1ns/1ps
module psp_core_tb;
   import psp_pkg::*;
   typedef struct packed {
      logic [7:0] host_byte;
      logic [7:0] fw_byte;
      logic [7:0] dir;
      logic       irq_en;
   } psp_row_t;
   psp_row_t     rows [4] = '{'{8'h00, 8'hff, 8'h00, 1'b1}, '{8'hff, 8'h00, 8'hff, 1'b0},
                              '{8'ha5, 8'h5a, 8'h0f, 1'b1}, '{8'h5a, 8'ha5, 8'hf0, 1'b0}};
   logic         core_clk;
   logic         srst;
   logic         slave_port_enable;
   logic         slave_port_irq_enable;
   logic [7:0]   port_d_direction;
   logic [7:0]   port_d_gpio_out;
   logic         cs_n;
   logic         wr_n;
   logic         rd_n;
   logic [7:0]   host_drive;
   logic [7:0]   bus;
   logic [7:0]   port_d_out;
   logic [7:0]   port_d_oe;
   logic         fw_write;
   logic [7:0]   fw_wdata;
   logic         fw_read;
   logic [7:0]   fw_rdata;
   logic         fw_write_ready;
   logic         fw_clear_irq;
   logic         fw_clear_overrun;
   psp_status_t  status;
   logic         slave_port_irq;
   logic [7:0]   got;
   int           fails;
   int           check_count;
   int           cycles;
   assign bus = (port_d_oe & port_d_out) | (~port_d_oe & host_drive);
   psp_core dut (.core_clk, .srst, .slave_port_enable, .slave_port_irq_enable,
      .port_d_direction, .port_d_gpio_out, .read_strobe_pin_n(rd_n),
      .write_strobe_pin_n(wr_n), .chip_select_pin_n(cs_n), .port_d_in(bus),
      .port_d_out, .port_d_oe, .fw_write, .fw_wdata, .fw_write_ready, .fw_read,
      .fw_rdata, .fw_clear_irq, .fw_clear_overrun, .status, .slave_port_irq);
   psp_host_model host (.core_clk, .bus_level(bus), .cs_n, .wr_n, .rd_n, .host_drive);
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   task automatic check8(input logic [7:0] g, input logic [7:0] e, input string what);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("wrong value at %0t: %s got %h want %h", $time, what, g, e);
      end
   endtask
   task automatic check1(input logic g, input logic e, input string what);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("wrong value at %0t: %s got %b want %b", $time, what, g, e);
      end
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic fw_rd(output logic [7:0] v);
      @(posedge core_clk);
      fw_read <= 1'b1;
      @(posedge core_clk);
      fw_read <= 1'b0;
      #1;
      v = fw_rdata;
      @(posedge core_clk);
      #1;
   endtask
   task automatic fw_wr(input logic [7:0] v);
      @(posedge core_clk);
      fw_write <= 1'b1;
      fw_wdata <= v;
      @(posedge core_clk);
      fw_write <= 1'b0;
      @(posedge core_clk);
      #1;
   endtask
   // one-cycle clear pulse: overrun when ovr is set, else irq flag
   task automatic fw_clear(input logic ovr);
      @(posedge core_clk);
      fw_clear_irq     <= ~ovr;
      fw_clear_overrun <= ovr;
      @(posedge core_clk);
      fw_clear_irq     <= 1'b0;
      fw_clear_overrun <= 1'b0;
      @(posedge core_clk);
      #1;
   endtask
   initial begin
      cycles = 0;
      forever begin
         @(posedge core_clk);
         cycles++;
         if (cycles == 20000) begin
            fails++;
            $display("wrong value at %0t: run timed out", $time);
            results();
         end
      end
   end
   initial begin
      fails = 0;
      check_count = 0;
      srst = 1'b1;
      slave_port_enable = 1'b1;
      slave_port_irq_enable = 1'b1;
      port_d_direction = 8'h00;
      port_d_gpio_out = 8'h00;
      fw_write = 1'b0;
      fw_wdata = 8'h00;
      fw_read = 1'b0;
      fw_clear_irq = 1'b0;
      fw_clear_overrun = 1'b0;
      repeat (4) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      #1;
      check8({4'h0, status}, 8'h00, "reset status");
      check8(port_d_oe, 8'h00, "reset drive");
      foreach (rows[i]) begin
         @(posedge core_clk);
         port_d_direction <= rows[i].dir;
         slave_port_irq_enable <= rows[i].irq_en;
         host.write_byte(rows[i].host_byte, (i % 2) ? 12 : 5);
         #1;
         check1(status.input_buffer_full, 1'b1, "input full");
         check1(status.slave_port_irq_flag, 1'b1, "irq on write");
         check1(slave_port_irq, rows[i].irq_en, "irq line");
         check8(port_d_oe, 8'h00, "idle drive");
         fw_rd(got);
         check8(got, rows[i].host_byte, "fw read");
         check1(status.input_buffer_full, 1'b0, "input full clear");
         check1(status.slave_port_irq_flag, 1'b1, "irq sticky");
         fw_clear(1'b0);
         check1(status.slave_port_irq_flag, 1'b0, "irq clear");
         fw_wr(rows[i].fw_byte);
         check1(status.output_buffer_full, 1'b1, "output full");
         fork
            host.read_byte(got, 10);
            begin
               repeat (9) @(posedge core_clk);
               #1;
               check1(status.output_buffer_full, 1'b0, "output full drop");
               check8(port_d_oe, 8'hff, "read drive");
               check1(fw_write_ready, 1'b0, "write refused");
            end
         join
         #1;
         check8(got, rows[i].fw_byte, "host read");
         check1(status.output_buffer_full, 1'b0, "output full low");
         check1(status.slave_port_irq_flag, 1'b1, "irq on read");
         check8(port_d_oe, 8'h00, "drive off");
         check1(fw_write_ready, 1'b1, "write open");
         fw_clear(1'b0);
      end
      // fill the queue, then drain it in order
      for (int k = 0; k < PSP_FIFO_DEPTH; k++) begin
         host.write_byte(8'(k) * 8'h11, 5);
      end
      #1;
      check1(status.input_overrun, 1'b1, "overrun");
      for (int k = 0; k < PSP_FIFO_DEPTH; k++) begin
         fw_rd(got);
         check8(got, 8'(k) * 8'h11, "queue order");
      end
      check1(status.input_buffer_full, 1'b0, "drained");
      fw_clear(1'b1);
      check1(status.input_overrun, 1'b0, "overrun clear");
      // leave slave mode with flags pending
      host.write_byte(8'h3c, 5);
      host.write_byte(8'hc3, 5);
      fw_wr(8'h77);
      @(posedge core_clk);
      slave_port_enable <= 1'b0;
      port_d_direction <= 8'h0f;
      port_d_gpio_out <= 8'h96;
      repeat (2) @(posedge core_clk);
      #1;
      check1(status.input_buffer_full, 1'b0, "off input full");
      check1(status.output_buffer_full, 1'b0, "off output full");
      check1(status.input_overrun, 1'b1, "off overrun");
      check8(port_d_oe, 8'hf0, "gpio drive");
      check8(port_d_out, 8'h96, "gpio data");
      host.write_byte(8'h55, 5);
      #1;
      check1(status.input_buffer_full, 1'b0, "off write");
      fw_clear(1'b1);
      check1(status.input_overrun, 1'b0, "off overrun clear");
      // mid-run reset drops queued bytes, latch and flags
      check1(status.slave_port_irq_flag, 1'b1, "irq before reset");
      @(posedge core_clk);
      srst <= 1'b1;
      repeat (4) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      #1;
      check8({4'h0, status}, 8'h00, "mid reset status");
      fw_rd(got);
      check8(got, 8'h00, "mid reset latch");
      results();
   end
endmodule
